/* rtl/mfa_pkg.sv */
package mfa_pkg;

  // ----------------------------------------------------------------
  // Widths and requester counts
  // ----------------------------------------------------------------
  localparam int          CODE_W      = 3;
  localparam int          FIELD_STEP  = 4;
  localparam int          MEM_REQ_N   = 7;
  localparam int          GEN_REQ_N   = 6;
  localparam int          ADR_W       = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOCAL_SET_OFF  = 8'h0c;
  localparam logic [7:0]  MASTER_SET_OFF = 8'h10;
  localparam logic [7:0]  GENERAL_SET_OFF = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          SCHEME_BIT     = 28;
  localparam int          VGA_LSB        = 24;
  localparam int          DMA_LSB        = 20;
  localparam int          CAP1_LSB       = 16;
  localparam int          CAP0_LSB       = 12;
  localparam int          VIDEO_LSB      = 8;
  localparam int          PANEL_LSB      = 4;
  localparam int          CRT_LSB        = 0;
  localparam int          GEN_PANEL_LSB  = 20;
  localparam int          GEN_CAP_LSB    = 16;
  localparam int          GEN_CMD_LSB    = 12;
  localparam int          GEN_DMA_LSB    = 8;
  localparam int          GEN_VIDEO_LSB  = 4;
  localparam int          GEN_CRT_LSB    = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] MEM_SET_RST    = 32'h01765324;
  localparam logic [31:0] GEN_SET_RST    = 32'h00000000;
  localparam logic [31:0] MEM_SET_MASK   = 32'h17777777;
  localparam logic [31:0] GEN_SET_MASK   = 32'h10777777;

  // ----------------------------------------------------------------
  // Bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } mfa_wb_req_s;

endpackage

/* rtl/mfa_arb_engine.sv */
`timescale 1ns/100ps
module mfa_arb_engine #(
  parameter int N = 7
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Settings
  input  wire logic                            revolve_i,
  input  wire logic [N*mfa_pkg::CODE_W-1:0]    code_i,
  // Requesters
  input  wire logic [N-1:0]                    req_i,
  output logic      [N-1:0]                    grant_o
);

  localparam int IW = $clog2(N);

  logic [N-1:0]               elig;
  logic [N-1:0]               grant_q;
  logic [N-1:0]               grant_d;
  logic [N-1:0]               pick;
  logic [IW-1:0]              last_q;
  logic [IW-1:0]              pick_idx;
  logic [mfa_pkg::CODE_W-1:0] gcode;

  // ----------------------------------------------------------------
  // Eligibility: a zero code switches the requester off
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_elig
    assign elig[g] = req_i[g] && (code_i[g*mfa_pkg::CODE_W +: mfa_pkg::CODE_W] != '0);
  end

  // ----------------------------------------------------------------
  // Winner selection, fixed or revolving
  // ----------------------------------------------------------------
  always_comb begin
    logic [mfa_pkg::CODE_W-1:0] best;
    logic                       found;
    int                         idx;
    best     = '1;
    found    = 1'b0;
    idx      = 0;
    pick     = '0;
    pick_idx = '0;
    if (!revolve_i) begin
      // Smallest nonzero code wins, lower index breaks ties
      for (int i = 0; i < N; i++) begin
        if (elig[i] && (!found || code_i[i*mfa_pkg::CODE_W +: mfa_pkg::CODE_W] < best)) begin
          best     = code_i[i*mfa_pkg::CODE_W +: mfa_pkg::CODE_W];
          found    = 1'b1;
          pick_idx = IW'(i);
        end
      end
    end else begin
      // Search starts just past the last winner, so it ranks last
      for (int k = 1; k <= N; k++) begin
        idx = (int'(last_q) + k) % N;
        if (elig[idx] && !found) begin
          found    = 1'b1;
          pick_idx = IW'(idx);
        end
      end
    end
    if (found) begin
      pick[pick_idx] = 1'b1;
    end
  end

  // Grant holds while its owner keeps asking, then a free cycle follows
  assign grant_d = (|grant_q) ? (grant_q & elig) : pick;

  // ----------------------------------------------------------------
  // Grant and last-winner registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= IW'(N - 1);
    end else if (!(|grant_q) && (|pick)) begin
      last_q <= pick_idx;
    end
  end

  assign grant_o = grant_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_comb begin
    gcode = '0;
    for (int i = 0; i < N; i++) begin
      if (grant_q[i]) begin
        gcode = code_i[i*mfa_pkg::CODE_W +: mfa_pkg::CODE_W];
      end
    end
  end

  chk_grant_one_hot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(grant_q))
    else $error("more than one grant");

  chk_grant_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    ((grant_q & elig) != '0) |=> (grant_q == $past(grant_q)))
    else $error("grant dropped while owner still requests");

  for (genvar g = 0; g < N; g++) begin : g_chk
    chk_off_never_granted: assert property (@(posedge clk_i) disable iff (rst_i)
      grant_q[g] |-> ($past(code_i[g*mfa_pkg::CODE_W +: mfa_pkg::CODE_W]) != '0))
      else $error("switched off requester holds a grant");

    chk_fixed_best_code: assert property (@(posedge clk_i) disable iff (rst_i)
      (!(|grant_q) && !revolve_i && elig[g] && $stable(code_i) && !$past(rst_i))
      |=> (|grant_q) && (gcode <= code_i[g*mfa_pkg::CODE_W +: mfa_pkg::CODE_W]))
      else $error("fixed scheme passed over a more urgent requester");
  end

  chk_revolve_rotates: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(|grant_q) && revolve_i && ((elig & ~(N'(1) << last_q)) != '0))
    |=> (grant_q != $past(grant_q)) && !grant_q[$past(last_q)])
    else $error("revolving scheme granted the last winner again");

endmodule

/* rtl/mfa_arbiter.sv */
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module mfa_arbiter (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Register bus
  input  wire mfa_pkg::mfa_wb_req_s         wb_i,
  output logic                              wb_ack_o,
  output logic [31:0]                       wb_dat_o,
  // Local memory requesters: 6 vga, 5 dma, 4 cap1, 3 cap0, 2 video, 1 panel, 0 crt
  input  wire logic [mfa_pkg::MEM_REQ_N-1:0] lm_req_i,
  output logic      [mfa_pkg::MEM_REQ_N-1:0] lm_grant_o,
  // External memory requesters, same order
  input  wire logic [mfa_pkg::MEM_REQ_N-1:0] xm_req_i,
  output logic      [mfa_pkg::MEM_REQ_N-1:0] xm_grant_o,
  // General requesters: 5 panel, 4 capture, 3 command, 2 dma, 1 video, 0 crt
  input  wire logic [mfa_pkg::GEN_REQ_N-1:0] gn_req_i,
  output logic      [mfa_pkg::GEN_REQ_N-1:0] gn_grant_o
);

  localparam int CW = mfa_pkg::CODE_W;

  logic [31:0]                             local_set_q;
  logic [31:0]                             master_set_q;
  logic [31:0]                             general_set_q;
  logic                                    ack_q;
  logic [31:0]                             rdat_q;
  logic [31:0]                             rdat_d;
  logic                                    access;
  logic [mfa_pkg::MEM_REQ_N*CW-1:0]        lm_codes;
  logic [mfa_pkg::MEM_REQ_N*CW-1:0]        xm_codes;
  logic [mfa_pkg::GEN_REQ_N*CW-1:0]        gn_codes;

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [mfa_pkg::ADR_W-1:0] adr,
                               input logic [7:0]                off);
    hit = (adr[mfa_pkg::ADR_W-1:2] == off[mfa_pkg::ADR_W-1:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    merge = res & mask;
  endfunction

  // True for any of the three mapped words
  function automatic logic mapped(input logic [mfa_pkg::ADR_W-1:0] adr);
    mapped = hit(adr, mfa_pkg::LOCAL_SET_OFF) || hit(adr, mfa_pkg::MASTER_SET_OFF)
             || hit(adr, mfa_pkg::GENERAL_SET_OFF);
  endfunction

  // One access per request; ack drops in the cycle after it rose
  assign access = wb_i.cyc && wb_i.stb && !ack_q;

  // ----------------------------------------------------------------
  // Bus acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // ----------------------------------------------------------------
  // Priority set registers
  // ----------------------------------------------------------------
  // Local memory set, scheme in bit 28
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_set_q <= mfa_pkg::MEM_SET_RST;
    end else if (access && wb_i.we && hit(wb_i.adr, mfa_pkg::LOCAL_SET_OFF)) begin
      local_set_q <= merge(local_set_q, wb_i.dat, wb_i.sel, mfa_pkg::MEM_SET_MASK);
    end
  end

  // External memory set, independent of the local one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_set_q <= mfa_pkg::MEM_SET_RST;
    end else if (access && wb_i.we && hit(wb_i.adr, mfa_pkg::MASTER_SET_OFF)) begin
      master_set_q <= merge(master_set_q, wb_i.dat, wb_i.sel, mfa_pkg::MEM_SET_MASK);
    end
  end

  // General set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_set_q <= mfa_pkg::GEN_SET_RST;
    end else if (access && wb_i.we && hit(wb_i.adr, mfa_pkg::GENERAL_SET_OFF)) begin
      general_set_q <= merge(general_set_q, wb_i.dat, wb_i.sel, mfa_pkg::GEN_SET_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Read data; unmapped words read zero and ignore writes
  // ----------------------------------------------------------------
  always_comb begin
    rdat_d = '0;
    if (hit(wb_i.adr, mfa_pkg::LOCAL_SET_OFF)) begin
      rdat_d = local_set_q;
    end else if (hit(wb_i.adr, mfa_pkg::MASTER_SET_OFF)) begin
      rdat_d = master_set_q;
    end else if (hit(wb_i.adr, mfa_pkg::GENERAL_SET_OFF)) begin
      rdat_d = general_set_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (access && !wb_i.we) begin
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Code extraction into requester order
  // ----------------------------------------------------------------
  assign lm_codes = {local_set_q[mfa_pkg::VGA_LSB +: CW],
                     local_set_q[mfa_pkg::DMA_LSB +: CW],
                     local_set_q[mfa_pkg::CAP1_LSB +: CW],
                     local_set_q[mfa_pkg::CAP0_LSB +: CW],
                     local_set_q[mfa_pkg::VIDEO_LSB +: CW],
                     local_set_q[mfa_pkg::PANEL_LSB +: CW],
                     local_set_q[mfa_pkg::CRT_LSB +: CW]};

  assign xm_codes = {master_set_q[mfa_pkg::VGA_LSB +: CW],
                     master_set_q[mfa_pkg::DMA_LSB +: CW],
                     master_set_q[mfa_pkg::CAP1_LSB +: CW],
                     master_set_q[mfa_pkg::CAP0_LSB +: CW],
                     master_set_q[mfa_pkg::VIDEO_LSB +: CW],
                     master_set_q[mfa_pkg::PANEL_LSB +: CW],
                     master_set_q[mfa_pkg::CRT_LSB +: CW]};

  assign gn_codes = {general_set_q[mfa_pkg::GEN_PANEL_LSB +: CW],
                     general_set_q[mfa_pkg::GEN_CAP_LSB +: CW],
                     general_set_q[mfa_pkg::GEN_CMD_LSB +: CW],
                     general_set_q[mfa_pkg::GEN_DMA_LSB +: CW],
                     general_set_q[mfa_pkg::GEN_VIDEO_LSB +: CW],
                     general_set_q[mfa_pkg::GEN_CRT_LSB +: CW]};

  // ----------------------------------------------------------------
  // Arbiters, one per priority set
  // ----------------------------------------------------------------
  mfa_arb_engine #(.N(mfa_pkg::MEM_REQ_N)) u_local (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .revolve_i (local_set_q[mfa_pkg::SCHEME_BIT]),
    .code_i    (lm_codes),
    .req_i     (lm_req_i),
    .grant_o   (lm_grant_o)
  );

  mfa_arb_engine #(.N(mfa_pkg::MEM_REQ_N)) u_master (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .revolve_i (master_set_q[mfa_pkg::SCHEME_BIT]),
    .code_i    (xm_codes),
    .req_i     (xm_req_i),
    .grant_o   (xm_grant_o)
  );

  mfa_arb_engine #(.N(mfa_pkg::GEN_REQ_N)) u_general (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .revolve_i (general_set_q[mfa_pkg::SCHEME_BIT]),
    .code_i    (gn_codes),
    .req_i     (gn_req_i),
    .grant_o   (gn_grant_o)
  );

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  // Ack is a single-cycle pulse
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  // Every request is answered at the next edge
  chk_ack_next_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_i.cyc && wb_i.stb && !ack_q) |=> ack_q)
    else $error("request not answered at the next edge");

  // Ack only answers a request
  chk_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |-> $past(access))
    else $error("ack without a request");

  // Full-word writes land masked
  chk_local_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && wb_i.we && wb_i.sel == 4'hf && hit(wb_i.adr, mfa_pkg::LOCAL_SET_OFF))
    |=> local_set_q == ($past(wb_i.dat) & mfa_pkg::MEM_SET_MASK))
    else $error("local set write not stored");

  chk_master_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && wb_i.we && wb_i.sel == 4'hf && hit(wb_i.adr, mfa_pkg::MASTER_SET_OFF))
    |=> master_set_q == ($past(wb_i.dat) & mfa_pkg::MEM_SET_MASK))
    else $error("master set write not stored");

  chk_general_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && wb_i.we && wb_i.sel == 4'hf && hit(wb_i.adr, mfa_pkg::GENERAL_SET_OFF))
    |=> general_set_q == ($past(wb_i.dat) & mfa_pkg::GEN_SET_MASK))
    else $error("general set write not stored");

  // A lone byte lane leaves the other lanes alone
  chk_master_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && wb_i.we && wb_i.sel == 4'h2 && hit(wb_i.adr, mfa_pkg::MASTER_SET_OFF))
    |=> master_set_q == ({$past(master_set_q[31:16]), $past(wb_i.dat[15:8]),
                          $past(master_set_q[7:0])} & mfa_pkg::MEM_SET_MASK))
    else $error("master set lane write wrong");

  // Writes to unmapped words change nothing
  chk_write_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && wb_i.we && !mapped(wb_i.adr))
    |=> $stable(local_set_q) && $stable(master_set_q) && $stable(general_set_q))
    else $error("unmapped write changed a set");

  // Reserved bits always stay zero
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((local_set_q & ~mfa_pkg::MEM_SET_MASK) == '0)
      && ((master_set_q & ~mfa_pkg::MEM_SET_MASK) == '0)
      && ((general_set_q & ~mfa_pkg::GEN_SET_MASK) == '0))
    else $error("reserved bit set");

  // Read data mirrors the addressed word
  chk_read_local: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_i.we && hit(wb_i.adr, mfa_pkg::LOCAL_SET_OFF))
    |=> wb_dat_o == $past(local_set_q))
    else $error("local set read wrong");

  chk_read_master: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_i.we && hit(wb_i.adr, mfa_pkg::MASTER_SET_OFF))
    |=> wb_dat_o == $past(master_set_q))
    else $error("master set read wrong");

  chk_read_general: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_i.we && hit(wb_i.adr, mfa_pkg::GENERAL_SET_OFF))
    |=> wb_dat_o == $past(general_set_q))
    else $error("general set read wrong");

  chk_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_i.we && !mapped(wb_i.adr)) |=> wb_dat_o == '0)
    else $error("unmapped read not zero");

  // Read data stands until the next read
  chk_read_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(access && !wb_i.we) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");

  // Sets and outputs leave reset at their defaults
  chk_reset_values: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> (local_set_q == mfa_pkg::MEM_SET_RST)
      && (master_set_q == mfa_pkg::MEM_SET_RST) && (general_set_q == mfa_pkg::GEN_SET_RST))
    else $error("priority sets not at reset values");

  chk_reset_quiet: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> !ack_q && (rdat_q == '0) && (lm_grant_o == '0)
      && (xm_grant_o == '0) && (gn_grant_o == '0))
    else $error("outputs not quiet after reset");

  // ----------------------------------------------------------------
  // Arbiter checks
  // ----------------------------------------------------------------
  // Grants go only to requesters that were asking
  chk_grant_requested: assert property (@(posedge clk_i) disable iff (rst_i)
    ((lm_grant_o & ~$past(lm_req_i)) == '0) && ((xm_grant_o & ~$past(xm_req_i)) == '0)
      && ((gn_grant_o & ~$past(gn_req_i)) == '0))
    else $error("grant without a request");

  // CRT at code seven loses to a more urgent panel under fixed priority
  chk_crt_last_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (xm_grant_o == '0 && !master_set_q[mfa_pkg::SCHEME_BIT] && xm_req_i[0] && xm_req_i[1]
      && master_set_q[mfa_pkg::CRT_LSB +: CW] == 3'h7
      && master_set_q[mfa_pkg::PANEL_LSB +: CW] != 3'h0
      && master_set_q[mfa_pkg::PANEL_LSB +: CW] != 3'h7)
    |=> !xm_grant_o[0])
    else $error("crt at code seven granted ahead of the panel");

endmodule

/* verif/mfa_req_model.sv */
`timescale 1ns/100ps
module mfa_req_model #(
  parameter int N    = 7,
  parameter int HOLD = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // One-shot demand from the bench, grants from the arbiter
  input  wire logic [N-1:0] want_i,
  input  wire logic [N-1:0] grant_i,
  // Level requests towards the arbiter
  output logic      [N-1:0] req_o
);
  // ----------------------------------------------------------------
  // Requester FIFOs
  // ----------------------------------------------------------------
  logic [N-1:0] req_q;
  logic [7:0]   cnt_q;
  logic [N-1:0] served;

  // A FIFO is served once it has held a grant for HOLD cycles
  assign served = (cnt_q == 8'(HOLD - 1)) ? (grant_i & req_q) : '0;
  assign req_o  = req_q;

  // Request stays up until served, so an ungranted FIFO waits forever
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= '0;
      cnt_q <= 8'h00;
    end else begin
      req_q <= (req_q | want_i) & ~served;
      cnt_q <= (|(grant_i & req_q) && served == '0) ? cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 clk_i    = 1'b0;
  logic                 rst_i    = 1'b1;
  mfa_pkg::mfa_wb_req_s wb_q     = '0;
  logic                 wb_ack_o;
  logic [31:0]          wb_dat_o;
  logic [6:0]           lm_req, lm_grant, xm_req, xm_grant;
  logic [5:0]           gn_req, gn_grant;
  logic [6:0]           lm_want  = '0;
  logic [6:0]           xm_want  = '0;
  logic [5:0]           gn_want  = '0;
  logic [6:0]           all_g, prev_g;
  logic [31:0]          rd;
  int                   bad_count   = 0;
  int                   checks_done = 0;
  int                   got[$];
  int                   exp_q[$];

  always #2 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Design and requester models
  // ----------------------------------------------------------------
  mfa_arbiter DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .lm_req_i(lm_req), .lm_grant_o(lm_grant), .xm_req_i(xm_req), .xm_grant_o(xm_grant),
    .gn_req_i(gn_req), .gn_grant_o(gn_grant));
  mfa_req_model #(.N(7)) u_lm (.clk_i(clk_i), .rst_i(rst_i), .want_i(lm_want),
    .grant_i(lm_grant), .req_o(lm_req));
  mfa_req_model #(.N(7)) u_xm (.clk_i(clk_i), .rst_i(rst_i), .want_i(xm_want),
    .grant_i(xm_grant), .req_o(xm_req));
  mfa_req_model #(.N(6)) u_gn (.clk_i(clk_i), .rst_i(rst_i), .want_i(gn_want),
    .grant_i(gn_grant), .req_o(gn_req));

  // Only one set is exercised at a time, so grants are merged
  assign all_g = lm_grant | xm_grant | {1'b0, gn_grant};

  // Log each new grant winner in order
  always @(posedge clk_i) begin
    if (!rst_i && all_g != prev_g && all_g != '0) begin
      for (int i = 0; i < 7; i++) if (all_g[i]) got.push_back(i);
    end
    prev_g = all_g;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", what, e, s);
      bad_count++;
    end
  endtask

  // Classic single cycle; held until ack is seen at a rising edge
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
    int n;
    n = 0;
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) chk("bus_ack", 32'h1, 32'h0);
    wb_q <= '0;
    @(posedge clk_i);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Reference order: fixed takes smallest code, lower index on a tie;
  // revolving scans upward from the last winner; code zero is skipped
  task automatic calc(input logic [31:0] w, input int n);
    bit pend[7];
    int last, best, i;
    exp_q.delete();
    last = n - 1;
    for (i = 0; i < n; i++) pend[i] = (w[4*i +: 3] != 3'h0);
    repeat (n) begin
      best = -1;
      for (int k = 1; k <= n; k++) begin
        i = w[mfa_pkg::SCHEME_BIT] ? (last + k) % n : k - 1;
        if (pend[i] && (best < 0 || (!w[mfa_pkg::SCHEME_BIT] &&
            w[4*i +: 3] < w[4*best +: 3]))) best = i;
      end
      if (best >= 0) begin
        exp_q.push_back(best);
        pend[best] = 0;
        last = best;
      end
    end
  endtask

  // All requesters of one set ask at once; grant order is compared
  task automatic run_case(input logic [7:0] off, input logic [31:0] w);
    int n;
    do_reset();
    wb_xfer(1'b1, off, w, 4'hf);
    n = (off == mfa_pkg::GENERAL_SET_OFF) ? 6 : 7;
    calc(w, n);
    got.delete();
    lm_want <= (off == mfa_pkg::LOCAL_SET_OFF) ? 7'h7f : 7'h00;
    xm_want <= (off == mfa_pkg::MASTER_SET_OFF) ? 7'h7f : 7'h00;
    gn_want <= (off == mfa_pkg::GENERAL_SET_OFF) ? 6'h3f : 6'h00;
    @(posedge clk_i);
    lm_want <= '0;
    xm_want <= '0;
    gn_want <= '0;
    for (int t = 0; t < 300 && got.size() < exp_q.size(); t++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    chk("grant_count", 32'(exp_q.size()), 32'(got.size()));
    for (int i = 0; i < exp_q.size() && i < got.size(); i++)
      chk("grant_index", 32'(exp_q[i]), 32'(got[i]));
  endtask

  task automatic end_sim();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    wb_xfer(1'b0, mfa_pkg::LOCAL_SET_OFF, 32'h0, 4'hf);
    chk("local_reset", mfa_pkg::MEM_SET_RST, rd);
    wb_xfer(1'b0, mfa_pkg::MASTER_SET_OFF, 32'h0, 4'hf);
    chk("master_reset", mfa_pkg::MEM_SET_RST, rd);
    wb_xfer(1'b0, mfa_pkg::GENERAL_SET_OFF, 32'h0, 4'hf);
    chk("general_reset", mfa_pkg::GEN_SET_RST, rd);
    // Reserved bits stay zero, one byte lane alone is written
    wb_xfer(1'b1, mfa_pkg::LOCAL_SET_OFF, 32'hffffffff, 4'hf);
    wb_xfer(1'b0, mfa_pkg::LOCAL_SET_OFF, 32'h0, 4'hf);
    chk("local_mask", mfa_pkg::MEM_SET_MASK, rd);
    wb_xfer(1'b1, mfa_pkg::GENERAL_SET_OFF, 32'hffffffff, 4'hf);
    wb_xfer(1'b0, mfa_pkg::GENERAL_SET_OFF, 32'h0, 4'hf);
    chk("general_mask", mfa_pkg::GEN_SET_MASK, rd);
    wb_xfer(1'b1, mfa_pkg::MASTER_SET_OFF, 32'h0, 4'h2);
    wb_xfer(1'b0, mfa_pkg::MASTER_SET_OFF, 32'h0, 4'hf);
    chk("master_lane", 32'h01760024, rd);
    wb_xfer(1'b1, 8'h30, 32'hffffffff, 4'hf);
    wb_xfer(1'b0, 8'h30, 32'h0, 4'hf);
    chk("unmapped", 32'h0, rd);
    // Arbitration orders
    run_case(mfa_pkg::LOCAL_SET_OFF, 32'h01765324);
    run_case(mfa_pkg::LOCAL_SET_OFF, 32'h11765320);
    run_case(mfa_pkg::MASTER_SET_OFF, 32'h02222227);
    run_case(mfa_pkg::MASTER_SET_OFF, 32'h12202227);
    run_case(mfa_pkg::GENERAL_SET_OFF, 32'h00415326);
    run_case(mfa_pkg::GENERAL_SET_OFF, 32'h10470011);
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end
endmodule
